// ### viu_pkg.sv
// Function
// - Sample and decode pending requests every clock
// - Least response seven clocks: detect, one boundary cycle, call
// - One instruction runs after return before call
// - Worst response nineteen clocks including return, divide
// - Equal or higher handler holds off new request
// - CPU stall after the detect cycle delays response by stall length
// - Fixed vectors eight bytes apart, lower order wins
// - Hardware clears external and timer 0/1 flags
// - Any of four serial flags raises request
// - Enable bit 7 gates every source
// - Enable bits 6..0 unmask individual sources
// - Timer 2 requests on low or high overflow
// - Enable register at 0xA8, bit-addressable, resets zero
// - Per-source priority bit; high preempts low only
// - Flag still set after return requests again
// - Extended enable: timer3, counter array, USB, SMBus
package viu_pkg;

	localparam int          LP_NUM_SRC    = 19;
	localparam int          LP_IDX_W      = 5;

	// Register addresses
	localparam logic [7:0]  LP_ADDR_IE    = 8'h_A8;
	localparam logic [7:0]  LP_ADDR_IP    = 8'h_B8;
	localparam logic [7:0]  LP_ADDR_EXTENDED_UNMASK_REG1  = 8'h_E6;
	localparam logic [7:0]  LP_ADDR_EIP1  = 8'h_F6;
	localparam logic [7:0]  LP_ADDR_EIE2  = 8'h_E7;
	localparam logic [7:0]  LP_ADDR_EIP2  = 8'h_F7;

	// Reset values and priority register read mask
	localparam logic [7:0]  LP_RST_IE     = 8'h_00;
	localparam logic [7:0]  LP_RST_IP     = 8'h_00;
	localparam logic [7:0]  LP_RST_EXT    = 8'h_00;
	localparam logic [7:0]  LP_IP_RD_ONE  = 8'h_80;

	// Field positions
	localparam int          LP_BIT_GATE   = 7;
	localparam int          LP_BIT_SPI    = 6;
	localparam int          LP_BIT_T2     = 5;
	localparam int          LP_BIT_UART0  = 4;
	localparam int          LP_BIT_T1     = 3;
	localparam int          LP_BIT_EXT1   = 2;
	localparam int          LP_BIT_T0     = 1;
	localparam int          LP_BIT_EXT0   = 0;
	localparam int          LP_BIT_T3     = 7;
	localparam int          LP_BIT_PCA    = 4;
	localparam int          LP_BIT_USB    = 1;
	localparam int          LP_BIT_SMB    = 0;
	localparam int          LP_BIT_MAT    = 3;
	localparam int          LP_BIT_UART1  = 1;
	localparam int          LP_BIT_VBUS   = 0;

	// Vector layout and timing
	localparam logic [15:0] LP_VEC_BASE   = 16'h_0003;
	localparam logic [15:0] LP_VEC_RESET  = 16'h_0000;
	localparam logic [2:0]  LP_CALL_CYC   = 3'h_5;
	localparam int          LP_DETECT_CYC = 1;

	typedef enum logic {VIU_IDLE, VIU_CALL} viu_state_e;

endpackage : viu_pkg

// ### viu_arbiter.sv
`timescale 1ns/100ps
// Fixed-order pick: lowest set index wins
module viu_arbiter #(
	parameter int N    = 19,
	parameter int IDXW = 5
) (
	input  wire logic [N-1:0]    i_req,
	output logic                 o_valid,
	output logic [IDXW-1:0]      o_index
);

	always_comb begin
		o_valid = 1'b0;
		o_index = '0;
		for (int k = N - 1; k >= 0; k--) begin
			if (i_req[k]) begin
				o_valid = 1'b1;
				o_index = IDXW'(k);
			end
		end
	end

endmodule : viu_arbiter

// ### viu_core.sv
`timescale 1ns/100ps
module viu_core #(
	parameter int NSRC = viu_pkg::LP_NUM_SRC,
	parameter int IDXW = viu_pkg::LP_IDX_W
) (
	input  wire logic        i_core_clk,
	input  wire logic        i_reset_n,
	// Register port
	input  wire logic [7:0]  i_sfr_addr,
	input  wire logic        i_sfr_wr,
	input  wire logic [7:0]  i_sfr_wdata,
	input  wire logic        i_sfr_bit_wr,
	input  wire logic [2:0]  i_sfr_bit_sel,
	input  wire logic        i_sfr_bit_val,
	output logic [7:0]       o_sfr_rdata,
	// Source flags
	input  wire logic        i_ext_line0_pending,
	input  wire logic        i_timer0_overflow_flag,
	input  wire logic        i_ext_line1_pending,
	input  wire logic        i_timer1_overflow_flag,
	input  wire logic        i_uart0_flag,
	input  wire logic        i_timer2_low_overflow_flag,
	input  wire logic        i_timer2_high_overflow_flag,
	input  wire logic        i_transfer_complete_flag,
	input  wire logic        i_write_collision_flag,
	input  wire logic        i_mode_fault_flag,
	input  wire logic        i_receive_overrun_flag,
	input  wire logic        i_smbus_flag,
	input  wire logic        i_usb_flag,
	input  wire logic        i_counter_array_flag,
	input  wire logic        i_timer3_low_overflow_flag,
	input  wire logic        i_timer3_high_overflow_flag,
	input  wire logic        i_vbus_level,
	input  wire logic        i_uart1_flag,
	input  wire logic        i_port_match,
	// CPU side
	input  wire logic        i_instr_done,
	input  wire logic        i_return_from_handler_done,
	input  wire logic        i_cpu_stall,
	output logic             o_long_call_active,
	output logic             o_handler_start,
	output logic [15:0]      o_call_vector,
	output logic             o_call_high,
	output logic             o_active_high,
	output logic             o_active_low,
	output logic             o_ext_line0_clear,
	output logic             o_timer0_clear,
	output logic             o_ext_line1_clear,
	output logic             o_timer1_clear
);

	logic                rst_meta_ff;
	logic                rst_sync_ff;
	logic [7:0]          ie_ff;
	logic [7:0]          ip_ff;
	logic [7:0]          extended_unmask_reg1_ff;
	logic [7:0]          eip1_ff;
	logic [7:0]          eie2_ff;
	logic [7:0]          eip2_ff;
	logic [NSRC-1:0]     req_ff;
	logic [NSRC-1:0]     src_pend;
	logic [NSRC-1:0]     src_en;
	logic [NSRC-1:0]     src_prio;
	logic [NSRC-1:0]     nxt_req;
	viu_pkg::viu_state_e state_ff;
	logic [2:0]          cnt_ff;
	logic                act_high_ff;
	logic                act_low_ff;
	logic                call_ff;
	logic                start_ff;
	logic [15:0]         vec_ff;
	logic                call_high_ff;
	logic [3:0]          clr_ff;
	logic [7:0]          rdata_ff;

	// Reset release through two flops
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	// Byte write, or single bit write on bit-addressable registers
	function automatic logic [7:0] sfr_next(input logic [7:0] old, input logic [7:0] addr,
		input logic bit_ok);
		logic [7:0] v;
		v = old;
		if (i_sfr_wr && i_sfr_addr == addr)
			v = i_sfr_wdata;
		else if (bit_ok && i_sfr_bit_wr && i_sfr_addr == addr)
			v[i_sfr_bit_sel] = i_sfr_bit_val;
		return v;
	endfunction : sfr_next

	wire logic [7:0] nxt_ie   = sfr_next(ie_ff, viu_pkg::LP_ADDR_IE, 1'b1);
	wire logic [7:0] nxt_ip   = sfr_next(ip_ff, viu_pkg::LP_ADDR_IP, 1'b1);
	wire logic [7:0] nxt_extended_unmask_reg1 = sfr_next(extended_unmask_reg1_ff, viu_pkg::LP_ADDR_EXTENDED_UNMASK_REG1, 1'b0);
	wire logic [7:0] nxt_eip1 = sfr_next(eip1_ff, viu_pkg::LP_ADDR_EIP1, 1'b0);
	wire logic [7:0] nxt_eie2 = sfr_next(eie2_ff, viu_pkg::LP_ADDR_EIE2, 1'b0);
	wire logic [7:0] nxt_eip2 = sfr_next(eip2_ff, viu_pkg::LP_ADDR_EIP2, 1'b0);

	always_ff @(posedge i_core_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			ie_ff   <= viu_pkg::LP_RST_IE;
			ip_ff   <= viu_pkg::LP_RST_IP;
			extended_unmask_reg1_ff <= viu_pkg::LP_RST_EXT;
			eip1_ff <= viu_pkg::LP_RST_EXT;
			eie2_ff <= viu_pkg::LP_RST_EXT;
			eip2_ff <= viu_pkg::LP_RST_EXT;
		end else begin
			ie_ff   <= nxt_ie;
			ip_ff   <= {1'b0, nxt_ip[6:0]};
			extended_unmask_reg1_ff <= nxt_extended_unmask_reg1;
			eip1_ff <= nxt_eip1;
			eie2_ff <= nxt_eie2;
			eip2_ff <= nxt_eip2;
		end
	end

	// Unused top bit of the priority register reads as one
	wire logic [7:0] rd_mux =
		(i_sfr_addr == viu_pkg::LP_ADDR_IE)   ? ie_ff :
		(i_sfr_addr == viu_pkg::LP_ADDR_IP)   ? (ip_ff | viu_pkg::LP_IP_RD_ONE) :
		(i_sfr_addr == viu_pkg::LP_ADDR_EXTENDED_UNMASK_REG1) ? extended_unmask_reg1_ff :
		(i_sfr_addr == viu_pkg::LP_ADDR_EIP1) ? eip1_ff :
		(i_sfr_addr == viu_pkg::LP_ADDR_EIE2) ? eie2_ff :
		(i_sfr_addr == viu_pkg::LP_ADDR_EIP2) ? eip2_ff : 8'h_00;

	// Source table in fixed order; reserved slots tied off
	assign src_pend = {
		i_port_match,
		1'b0,
		i_uart1_flag,
		i_vbus_level,
		i_timer3_low_overflow_flag | i_timer3_high_overflow_flag,
		2'b00,
		i_counter_array_flag,
		2'b00,
		i_usb_flag,
		i_smbus_flag,
		i_transfer_complete_flag | i_write_collision_flag |
			i_mode_fault_flag | i_receive_overrun_flag,
		i_timer2_low_overflow_flag | i_timer2_high_overflow_flag,
		i_uart0_flag,
		i_timer1_overflow_flag,
		i_ext_line1_pending,
		i_timer0_overflow_flag,
		i_ext_line0_pending};

	assign src_en = {
		eie2_ff[viu_pkg::LP_BIT_MAT], 1'b0, eie2_ff[viu_pkg::LP_BIT_UART1],
		eie2_ff[viu_pkg::LP_BIT_VBUS], extended_unmask_reg1_ff[viu_pkg::LP_BIT_T3], 2'b00,
		extended_unmask_reg1_ff[viu_pkg::LP_BIT_PCA], 2'b00, extended_unmask_reg1_ff[viu_pkg::LP_BIT_USB],
		extended_unmask_reg1_ff[viu_pkg::LP_BIT_SMB],
		ie_ff[6:0]};

	assign src_prio = {
		eip2_ff[viu_pkg::LP_BIT_MAT], 1'b0, eip2_ff[viu_pkg::LP_BIT_UART1],
		eip2_ff[viu_pkg::LP_BIT_VBUS], eip1_ff[viu_pkg::LP_BIT_T3], 2'b00,
		eip1_ff[viu_pkg::LP_BIT_PCA], 2'b00, eip1_ff[viu_pkg::LP_BIT_USB],
		eip1_ff[viu_pkg::LP_BIT_SMB], ip_ff[6:0]};

	assign nxt_req = src_pend & src_en & {NSRC{ie_ff[viu_pkg::LP_BIT_GATE]}};

	// Fresh sample each clock; a flag left set after return requests again
	always_ff @(posedge i_core_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff)
			req_ff <= '0;
		else
			req_ff <= nxt_req;
	end

	logic            hi_valid;
	logic            lo_valid;
	logic [IDXW-1:0] hi_idx;
	logic [IDXW-1:0] lo_idx;

	viu_arbiter #(.N(NSRC), .IDXW(IDXW)) u_arb_high (
		.i_req   (req_ff & src_prio),
		.o_valid (hi_valid),
		.o_index (hi_idx)
	);

	viu_arbiter #(.N(NSRC), .IDXW(IDXW)) u_arb_low (
		.i_req   (req_ff & ~src_prio),
		.o_valid (lo_valid),
		.o_index (lo_idx)
	);

	// High preempts low; nothing preempts high; equal level waits
	wire logic            pick_high = hi_valid && !act_high_ff;
	wire logic            pick_low  = lo_valid && !act_high_ff && !act_low_ff;
	wire logic            pick      = pick_high || pick_low;
	wire logic [IDXW-1:0] win_idx   = pick_high ? hi_idx : lo_idx;
	// The return's own boundary is skipped so one more instruction runs
	wire logic            take      = (state_ff == viu_pkg::VIU_IDLE) && i_instr_done &&
		!i_return_from_handler_done && !i_cpu_stall && pick;
	wire logic [15:0]     win_vec   = viu_pkg::LP_VEC_BASE +
		{{(13 - IDXW){1'b0}}, win_idx, 3'b000};
	wire logic            call_last = (cnt_ff == viu_pkg::LP_CALL_CYC - 3'h_1) && !i_cpu_stall;

	always_ff @(posedge i_core_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			state_ff <= viu_pkg::VIU_IDLE;
			cnt_ff   <= 3'h_0;
		end else begin
			unique case (state_ff)
				viu_pkg::VIU_IDLE: begin
					cnt_ff <= 3'h_0;
					if (take)
						state_ff <= viu_pkg::VIU_CALL;
				end
				viu_pkg::VIU_CALL: begin
					// Stall freezes the call count
					if (call_last)
						state_ff <= viu_pkg::VIU_IDLE;
					else if (!i_cpu_stall)
						cnt_ff <= cnt_ff + 3'h_1;
				end
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			call_ff      <= 1'b0;
			start_ff     <= 1'b0;
			vec_ff       <= viu_pkg::LP_VEC_RESET;
			call_high_ff <= 1'b0;
			clr_ff       <= 4'h_0;
			rdata_ff     <= 8'h_00;
		end else begin
			call_ff      <= take || (call_ff && !call_last);
			start_ff     <= (state_ff == viu_pkg::VIU_CALL) && call_last;
			vec_ff       <= take ? win_vec : vec_ff;
			call_high_ff <= take ? pick_high : call_high_ff;
			clr_ff[0]    <= take && win_idx == IDXW'(0);
			clr_ff[1]    <= take && win_idx == IDXW'(1);
			clr_ff[2]    <= take && win_idx == IDXW'(2);
			clr_ff[3]    <= take && win_idx == IDXW'(3);
			rdata_ff     <= rd_mux;
		end
	end

	// Return ends the highest level in service
	always_ff @(posedge i_core_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			act_high_ff <= 1'b0;
			act_low_ff  <= 1'b0;
		end else begin
			if (take && pick_high)
				act_high_ff <= 1'b1;
			else if (i_return_from_handler_done)
				act_high_ff <= 1'b0;
			if (take && !pick_high)
				act_low_ff <= 1'b1;
			else if (i_return_from_handler_done && !act_high_ff)
				act_low_ff <= 1'b0;
		end
	end

	assign o_sfr_rdata        = rdata_ff;
	assign o_long_call_active = call_ff;
	assign o_handler_start    = start_ff;
	assign o_call_vector      = vec_ff;
	assign o_call_high        = call_high_ff;
	assign o_active_high      = act_high_ff;
	assign o_active_low       = act_low_ff;
	assign o_ext_line0_clear  = clr_ff[0];
	assign o_timer0_clear     = clr_ff[1];
	assign o_ext_line1_clear  = clr_ff[2];
	assign o_timer1_clear     = clr_ff[3];

	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!rst_sync_ff);

	sequence s_take_clean;
		take ##1 (!i_cpu_stall) [*5];
	endsequence

	property p_sample;
		nxt_req[0] |=> req_ff[0];
	endproperty
	a_sample: assert property (p_sample) else $error("request not sampled");

	property p_call_len;
		s_take_clean |=> o_handler_start;
	endproperty
	a_call_len: assert property (p_call_len) else $error("call not five cycles");

	property p_no_early;
		take |=> !o_handler_start [*4];
	endproperty
	a_no_early: assert property (p_no_early) else $error("handler started early");

	property p_return_from_handler_skip;
		i_return_from_handler_done |-> !take;
	endproperty
	a_return_from_handler_skip: assert property (p_return_from_handler_skip) else $error("call on return");

	property p_hold_off;
		(take && !pick_high) |-> (!act_high_ff && !act_low_ff);
	endproperty
	a_hold_off: assert property (p_hold_off) else $error("low taken while busy");

	property p_stall;
		(call_ff && i_cpu_stall) |=> !o_handler_start;
	endproperty
	a_stall: assert property (p_stall) else $error("start during stall");

	property p_vector;
		o_handler_start |-> (o_call_vector[2:0] == 3'h_3 && o_call_vector <= 16'h_0093);
	endproperty
	a_vector: assert property (p_vector) else $error("bad vector");

	property p_hw_clear;
		(take && win_idx == IDXW'(0)) |=> o_ext_line0_clear;
	endproperty
	a_hw_clear: assert property (p_hw_clear) else $error("flag not cleared");

	property p_gate;
		!ie_ff[viu_pkg::LP_BIT_GATE] |=> (req_ff == '0);
	endproperty
	a_gate: assert property (p_gate) else $error("gate off yet request");

	property p_reserved;
		req_ff[9] == 1'b0 && req_ff[10] == 1'b0 && req_ff[17] == 1'b0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved slot active");

	property p_high_keep;
		act_high_ff && !i_return_from_handler_done |=> act_high_ff;
	endproperty
	a_high_keep: assert property (p_high_keep) else $error("high preempted");

endmodule : viu_core

// ### viu_cpu_model.sv
`timescale 1ns/100ps
// CPU instruction stream and holders of the hardware-cleared flags
module viu_cpu_model #(
	parameter int RETURN_FROM_HANDLER_LEN = 6
) (
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_call,
	input  wire logic       i_stall,
	input  wire logic       i_go_return_from_handler,
	input  wire logic [3:0] i_len,
	input  wire logic [3:0] i_set,
	input  wire logic [3:0] i_clr,
	output logic [3:0]      o_flag,
	output logic            o_done,
	output logic            o_return_from_handler
);
	logic [3:0] cnt_ff, len_ff, flag_ff, cur_len;
	logic       rt_ff, pend_ff, run, first, is_rt;
	assign run     = !i_call && !i_stall;
	assign first   = cnt_ff == 4'h_0;
	assign is_rt   = first ? (pend_ff | i_go_return_from_handler) : rt_ff;
	assign cur_len = first ? (is_rt ? 4'(RETURN_FROM_HANDLER_LEN) : i_len) : len_ff;
	assign o_done  = run && (cnt_ff == cur_len - 4'h_1);
	assign o_return_from_handler  = o_done && is_rt;
	// Set wins over the clear pulse, so a new event is never lost
	assign o_flag  = flag_ff | i_set;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_ff  <= 4'h_0;
			len_ff  <= 4'h_1;
			flag_ff <= 4'h_0;
			rt_ff   <= 1'b0;
			pend_ff <= 1'b0;
		end else begin
			flag_ff <= (flag_ff & ~i_clr) | i_set;
			pend_ff <= (pend_ff | i_go_return_from_handler) & !(run && first);
			if (run) begin
				cnt_ff <= o_done ? 4'h_0 : cnt_ff + 4'h_1;
			end
			if (run && first) begin
				len_ff <= cur_len;
				rt_ff  <= is_rt;
			end
		end
	end
endmodule : viu_cpu_model

// ### vectored_two_level_interrupt_unit_bench.sv
`timescale 1ns/100ps
module vectored_two_level_interrupt_unit_bench;
	logic        clk, rst_n, wr, bwr, bval, go_return_from_handler, stall, done, return_from_handler, call, hs, chigh, ahi, alo;
	logic [7:0]  addr, wdata, rdata, ie, ip, e1, p1, e2, p2;
	logic [2:0]  bsel;
	logic [3:0]  len, hflag, hclr;
	logic [18:0] sf, pat;
	logic [15:0] vec;
	logic [31:0] seed;
	logic [7:0]  al [7] = '{8'h_A8, 8'h_B8, 8'h_E6, 8'h_F6, 8'h_E7, 8'h_F7, 8'h_55};
	int          fails, check_count, eo;

	viu_core viu_core_i (
		.i_core_clk(clk), .i_reset_n(rst_n), .i_sfr_addr(addr), .i_sfr_wr(wr),
		.i_sfr_wdata(wdata), .i_sfr_bit_wr(bwr), .i_sfr_bit_sel(bsel), .i_sfr_bit_val(bval),
		.o_sfr_rdata(rdata), .i_ext_line0_pending(hflag[0]), .i_timer0_overflow_flag(hflag[1]),
		.i_ext_line1_pending(hflag[2]), .i_timer1_overflow_flag(hflag[3]), .i_uart0_flag(sf[4]),
		.i_timer2_low_overflow_flag(sf[5]), .i_timer2_high_overflow_flag(sf[9]),
		.i_transfer_complete_flag(sf[6]), .i_write_collision_flag(sf[10]),
		.i_mode_fault_flag(sf[12]), .i_receive_overrun_flag(sf[13]), .i_smbus_flag(sf[7]),
		.i_usb_flag(sf[8]), .i_counter_array_flag(sf[11]), .i_timer3_low_overflow_flag(sf[14]),
		.i_timer3_high_overflow_flag(sf[17]), .i_vbus_level(sf[15]), .i_uart1_flag(sf[16]),
		.i_port_match(sf[18]), .i_instr_done(done), .i_return_from_handler_done(return_from_handler), .i_cpu_stall(stall),
		.o_long_call_active(call), .o_handler_start(hs), .o_call_vector(vec), .o_call_high(chigh),
		.o_active_high(ahi), .o_active_low(alo), .o_ext_line0_clear(hclr[0]),
		.o_timer0_clear(hclr[1]), .o_ext_line1_clear(hclr[2]), .o_timer1_clear(hclr[3]));
	viu_cpu_model viu_cpu_model_i (.i_clk(clk), .i_rst_n(rst_n), .i_call(call), .i_stall(stall),
		.i_go_return_from_handler(go_return_from_handler), .i_len(len), .i_set(sf[3:0]), .i_clr(hclr), .o_flag(hflag),
		.o_done(done), .o_return_from_handler(return_from_handler));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Whole run needs about 1600 cycles
	initial begin
		repeat (8000) @(posedge clk);
		fails++;
		end_sim();
	end

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	// Enable or level bits spread onto arbitration order positions
	function automatic logic [18:0] by_ord(logic [7:0] a, logic [7:0] b, logic [7:0] c);
		return {c[3], 1'b0, c[1:0], b[7], 2'b00, b[4], 2'b00, b[1:0], a[6:0]};
	endfunction : by_ord
	function automatic int ord(int k);
		if (k == 9) return 5;
		if (k == 10 || k == 12 || k == 13) return 6;
		if (k == 17) return 14;
		return k;
	endfunction : ord
	function automatic int pick(logic [18:0] p);
		logic [18:0] r, h;
		r = '0;
		for (int k = 0; k < 19; k++) if (p[k]) r[ord(k)] = 1'b1;
		r = r & by_ord(ie, e1, e2) & {19{ie[7]}};
		h = by_ord(ip, p1, p2);
		for (int o = 0; o < 19; o++) if (r[o] && h[o]) return o;
		for (int o = 0; o < 19; o++) if (r[o]) return o;
		return -1;
	endfunction : pick
	function automatic logic [7:0] shadow(logic [7:0] a);
		return a == 8'h_A8 ? ie : a == 8'h_B8 ? (ip | 8'h_80) : a == 8'h_E6 ? e1 :
			a == 8'h_F6 ? p1 : a == 8'h_E7 ? e2 : a == 8'h_F7 ? p2 : 8'h_00;
	endfunction : shadow

	task automatic tick();
		@(posedge clk);
		#1;
	endtask : tick
	task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
		check_count++;
		if (got !== ex) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		// Idle edge first so the strobe never drops and rises in one step
		tick();
		addr = a;
		wdata = d;
		wr = 1'b1;
		tick();
		wr = 1'b0;
		if (a == 8'h_A8) ie = d;
		if (a == 8'h_B8) ip = d;
		if (a == 8'h_E6) e1 = d;
		if (a == 8'h_F6) p1 = d;
		if (a == 8'h_E7) e2 = d;
		if (a == 8'h_F7) p2 = d;
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a);
		addr = a;
		tick();
		chk("sfr_read", {8'h_00, shadow(a)}, {8'h_00, rdata});
	endtask : rd_reg
	// Optional return and flags raised in the same step; expects order eo after en edges, or none
	task automatic run(input bit rt, input logic [3:0] ln, input logic [18:0] p, input int st,
			input int eo, input int en);
		int n;
		logic [18:0] h;
		n = 0;
		h = by_ord(ip, p1, p2);
		tick();
		go_return_from_handler = rt;
		len = ln;
		sf = sf | p;
		stall = st > 0;
		do begin
			tick();
			n++;
			if (n == 1) begin
				go_return_from_handler = 1'b0;
				sf[3:0] = 4'h_0;
			end
			if (n == st) stall = 1'b0;
		end while (hs !== 1'b1 && n < 40);
		len = 4'h_1;
		if (eo < 0) begin
			chk("no_call", 16'd40, 16'(n));
			return;
		end
		chk("latency", 16'(en), 16'(n));
		chk("vector", 16'h_0003 + 16'(8 * eo), vec);
		chk("level", {15'h_0, h[eo]}, {15'h_0, chigh});
		chk("active", 16'h_1, {15'h_0, h[eo] ? ahi : alo});
		chk("call_active", 16'h_0, {15'h_0, call});
		if (eo < 4) chk("hw_clear", 16'h_0, {15'h_0, hflag[eo]});
	endtask : run
	task automatic done_test(input string nm);
		$display("test %s finished", nm);
	endtask : done_test
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : end_sim

	initial begin
		seed = 32'h_3576_2fef;
		{rst_n, wr, bwr, bval, go_return_from_handler, stall} = '0;
		{addr, wdata, bsel, len, sf} = '0;
		{ie, ip, e1, p1, e2, p2} = '0;
		len = 4'h_1;
		fails = 0;
		check_count = 0;
		repeat (12) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (3) tick();
		foreach (al[i]) rd_reg(al[i]);
		wr_reg(8'h_A8, 8'h_01);
		{addr, bsel, bval, bwr} = {8'h_A8, 3'h_7, 2'b11};
		tick();
		bwr = 1'b0;
		ie[7] = 1'b1;
		wr_reg(8'h_B8, 8'h_7F);
		wr_reg(8'h_E6, 8'h_93);
		wr_reg(8'h_E7, 8'h_0B);
		wr_reg(8'h_55, 8'h_FF);
		foreach (al[i]) rd_reg(al[i]);
		done_test("registers");
		wr_reg(8'h_A8, 8'h_FF);
		wr_reg(8'h_B8, 8'h_00);
		for (int k = 0; k < 19; k++) begin
			run(1'b0, 4'h_1, 19'(1 << k), 0, ord(k), 7);
			sf = '0;
			run(1'b1, 4'h_1, '0, 0, -1, 0);
		end
		done_test("sources");
		repeat (8) begin
			wr_reg(8'h_A8, 8'(xs()));
			wr_reg(8'h_B8, 8'(xs()));
			wr_reg(8'h_F6, 8'(xs()));
			pat = 19'(xs()) & 19'h_7_FFF0;
			eo = pick(pat);
			run(1'b0, 4'h_1, pat, 0, eo, 7);
			sf = '0;
			if (eo >= 0) run(1'b1, 4'h_1, '0, 0, -1, 0);
		end
		done_test("random");
		wr_reg(8'h_A8, 8'h_83);
		wr_reg(8'h_B8, 8'h_00);
		wr_reg(8'h_F6, 8'h_00);
		run(1'b0, 4'h_1, 19'h_1, 4, 0, 10);
		run(1'b1, 4'h_8, 19'h_2, 0, 1, 19);
		run(1'b1, 4'h_1, '0, 0, -1, 0);
		done_test("latency");
		wr_reg(8'h_A8, 8'h_95);
		wr_reg(8'h_B8, 8'h_04);
		run(1'b0, 4'h_1, 19'h_1, 0, 0, 7);
		run(1'b0, 4'h_1, 19'h_4, 0, 2, 7);
		run(1'b0, 4'h_1, 19'h_10, 0, -1, 0);
		run(1'b1, 4'h_1, '0, 0, -1, 0);
		run(1'b1, 4'h_1, '0, 0, 4, 12);
		sf = '0;
		run(1'b1, 4'h_1, '0, 0, -1, 0);
		done_test("preempt");
		end_sim();
	end
endmodule : vectored_two_level_interrupt_unit_bench
